// ### dv/host_register_access_port_tb.sv
// testbench: host end against device end, plus a pin-driven second device
`timescale 1ns/1ps
module host_register_access_port_tb
    import hrap_pkg::*;
;
    logic clk, rstn, rst2N, strapLevel, reqValid, reqWrite, reqReady, rspValid;
    logic quietBusy, quiet2, seenQuiet;
    logic [ADDR_W-1:0] reqAddr;
    logic [DATA_W-1:0] reqWdata, rspData;
    hrap_mode_t styleMode, style2;
    int err_count, n_compared;

    hrap_if bus ();
    hrap_if bus2 ();
    hrap_host u_hrap_host (.clk(clk), .rstn(rstn), .bus(bus), .strapLevel(strapLevel),
        .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
        .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    hrap_device u_hrap_device (.clk(clk), .rstn(rstn), .bus(bus), .styleMode(styleMode),
        .quietBusy(quietBusy));
    // second device lets the bench break host timing on purpose
    hrap_device u_hrap_device2 (.clk(clk), .rstn(rst2N), .bus(bus2), .styleMode(style2),
        .quietBusy(quiet2));
    hrap_sva u_hrap_sva (.clk(clk), .rstn(rstn), .csN(bus.csN), .strobeN(bus.strobeN),
        .wrRwN(bus.wrRwN), .addr(bus.addr), .hostDataOeN(bus.hostDataOeN),
        .devDataOeN(bus.devDataOeN), .ackOeN(bus.ackOeN), .ackBus(bus.ackBus));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) if (quietBusy === 1'b1) seenQuiet <= 1'b1;

    // ****************************************
    // compare and closing
    // ****************************************
    task automatic chkByte(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkMode(input string what, input hrap_mode_t got, input hrap_mode_t exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // drivers
    // ****************************************
    task automatic host_access(input logic wr, input logic [6:0] a, input logic [7:0] d,
            output logic [7:0] rd);
        int n;
        rd = 8'hxx;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqWdata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (reqReady !== 1'b1 && n < 400);
        reqValid <= 1'b0;
        repeat (2) @(posedge clk);
        while (reqReady !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
            if (rspValid === 1'b1) rd = rspData;
        end
        if (n >= 400) begin
            err_count++;
            $display("MISMATCH %0t host access stalled", $time);
        end
    endtask

    // lag of 40 or more means the strobe never falls
    task automatic pin_access(input logic sep, input logic wr, input logic [6:0] a,
            input logic [7:0] d, input int lag, output logic [7:0] rd, output logic acked);
        int n;
        acked = 1'b0;
        rd = 8'hxx;
        bus2.csN <= 1'b0;
        bus2.addr <= a;
        bus2.hostData <= d;
        bus2.hostDataOeN <= !wr;
        bus2.wrRwN <= sep ? 1'b1 : !wr;
        repeat (lag) @(posedge clk);
        if (lag < 40) begin
            bus2.strobeN <= sep ? wr : 1'b0;
            bus2.wrRwN <= !wr;
        end
        for (n = 0; n < 20 && !acked; n++) begin
            @(posedge clk);
            if (bus2.ackBus === 1'b0) begin
                acked = 1'b1;
                rd = bus2.dataBus;
            end
        end
        bus2.strobeN <= 1'b1;
        bus2.wrRwN <= 1'b1;
        @(posedge clk);
        bus2.csN <= 1'b1;
        bus2.hostDataOeN <= 1'b1;
        bus2.hostData <= ~d;
        repeat (8) @(posedge clk);
    endtask

    task automatic reset_dev2(input logic strapVal);
        rst2N <= 1'b0;
        bus2.strap <= strapVal;
        repeat (3) @(posedge clk);
        rst2N <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_normal();
        logic [7:0] rd;
        host_access(1'b1, 7'h05, 8'h3c, rd);
        chkMode("first write style", styleMode, MODE_NORMAL);
        host_access(1'b1, 7'h05, 8'ha5, rd);
        host_access(1'b1, 7'h12, 8'h5a, rd);
        host_access(1'b0, 7'h05, 8'h00, rd);
        chkByte("read odd", rd, 8'ha5);
        host_access(1'b0, 7'h12, 8'h00, rd);
        chkByte("read even", rd, 8'h5a);
        host_access(1'b0, 7'h7f, 8'h00, rd);
        chkByte("read untouched", rd, REG_RESET);
        chkByte("no early quiet", {7'h00, seenQuiet}, 8'h00);
        $display("test normal done");
    endtask

    task automatic test_soft_reset();
        logic [7:0] rd;
        host_access(1'b1, CMD2_ADDR, 8'h01 << CMD2_SWRST_BIT, rd);
        host_access(1'b0, 7'h05, 8'h00, rd);
        chkByte("quiet seen", {7'h00, seenQuiet}, 8'h01);
        chkByte("cleared after reset", rd, REG_RESET);
        host_access(1'b0, CMD2_ADDR, 8'h00, rd);
        chkByte("reset bit self clears", rd, 8'h00);
        chkByte("quiet over", {7'h00, quietBusy}, 8'h00);
        $display("test soft reset done");
    endtask

    task automatic test_sep();
        logic [7:0] rd;
        logic ak;
        reset_dev2(1'b1);
        chkMode("strap high", style2, MODE_SEP);
        pin_access(1'b1, 1'b1, 7'h22, 8'h99, 2, rd, ak);
        chkByte("sep write ack", {7'h00, ak}, 8'h01);
        pin_access(1'b1, 1'b0, 7'h22, 8'h00, 2, rd, ak);
        chkByte("sep read", rd, 8'h99);
        $display("test separate strobes done");
    endtask

    task automatic test_detect(input logic wr, input int lag, input hrap_mode_t exp,
            input string nm);
        logic [7:0] rd;
        logic ak;
        reset_dev2(1'b0);
        chkMode("before first access", style2, MODE_UNDET);
        pin_access(1'b0, wr, 7'h10, 8'h77, lag, rd, ak);
        chkMode(nm, style2, exp);
        $display("test detect %s done", nm);
    endtask

    initial begin
        err_count = 0;
        n_compared = 0;
        seenQuiet = 1'b0;
        rstn = 1'b0;
        rst2N = 1'b0;
        strapLevel = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 7'h00;
        reqWdata = 8'h00;
        bus2.csN = 1'b1;
        bus2.strobeN = 1'b1;
        bus2.wrRwN = 1'b1;
        bus2.addr = 7'h00;
        bus2.strap = 1'b0;
        bus2.hostData = 8'h00;
        bus2.hostDataOeN = 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        test_normal();
        test_soft_reset();
        test_sep();
        test_detect(1'b0, 3, MODE_NORMAL, "fast read");
        test_detect(1'b0, 14, MODE_SAR, "slow read");
        test_detect(1'b1, 2, MODE_NORMAL, "strobed write");
        test_detect(1'b1, 40, MODE_SAR, "unstrobed write");
        complete_run();
    end

    // whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("MISMATCH %0t watchdog expired", $time);
        complete_run();
    end
endmodule

// ### dv/hrap_sva.sv
// pin-level checker for the link between host end and device end
`timescale 1ns/1ps
module hrap_sva
    import hrap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host driven pins
    input wire logic csN,
    input wire logic strobeN,
    input wire logic wrRwN,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic hostDataOeN,
    // device driven pins
    input wire logic devDataOeN,
    input wire logic ackOeN,
    input wire logic ackBus
);
    logic [3:0] gapCnt_q;
    logic [3:0] lowCnt_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // ****************************************
    // strobe timing helpers
    // ****************************************
    // starts saturated so the very first strobe is not judged on its gap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gapCnt_q <= 4'hf;
        end else if (!strobeN) begin
            gapCnt_q <= 4'h0;
        end else if (gapCnt_q != 4'hf) begin
            gapCnt_q <= gapCnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lowCnt_q <= 4'h0;
        end else if (strobeN) begin
            lowCnt_q <= 4'h0;
        end else if (lowCnt_q != 4'hf) begin
            lowCnt_q <= lowCnt_q + 4'h1;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_unsel_float: assert property (csN [*8] |-> ackOeN && devDataOeN)
        else $error("ack or data driven while unselected");
    a_sync_delay: assert property ($fell(strobeN) |-> ackBus ##1 ackBus)
        else $error("ack answered an unsynchronised strobe");
    a_ack_bound: assert property ($fell(ackBus) |-> lowCnt_q >= 4'h3 && lowCnt_q <= 4'hc)
        else $error("ack latency out of range");
    a_ack_cause: assert property ($fell(ackBus) |-> !csN && !strobeN)
        else $error("ack without select and strobe");
    a_ack_holds: assert property ($fell(ackBus) |=> !ackBus [*2])
        else $error("ack dropped too early");
    a_read_drive: assert property (!ackBus && wrRwN && !strobeN |-> !devDataOeN)
        else $error("read ack without data driven");
    a_write_nodrive: assert property (!wrRwN |-> devDataOeN)
        else $error("device drove bus during write");
    a_strobe_gap: assert property ($fell(strobeN) |-> gapCnt_q >= 4'h4)
        else $error("strobe recovery too short");
    a_cs_first: assert property ($fell(strobeN) |-> !csN && $past(!csN))
        else $error("strobe before select");
    a_addr_steady: assert property (!strobeN ##1 !strobeN |-> $stable(addr))
        else $error("address moved during strobe");
    a_read_release: assert property ($rose(strobeN) && wrRwN |-> $past(!ackBus))
        else $error("read strobe raised before ack");
    a_write_data: assert property (!csN && !wrRwN |-> !hostDataOeN)
        else $error("write without host data");

    c_read_ack: cover property ($fell(ackBus) && wrRwN);
    c_write_ack: cover property ($fell(ackBus) && !wrRwN);
    c_deselect: cover property ($rose(csN));
endmodule

// ### logic/hrap_device.sv
// device end of the host register access port: style detect, handshake, registers
`timescale 1ns/1ps
module hrap_device
    import hrap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // host pins
    hrap_if.dev bus,
    // user side status
    output hrap_mode_t styleMode,
    output logic quietBusy
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [2:0] pinS1_q;
    logic [2:0] pinS2_q;
    logic [2:0] pinS3_q;
    logic [2:0] pinF_q;
    logic [ADDR_W-1:0] addrS_q;
    logic [DATA_W-1:0] dataS_q;
    logic [DATA_W-1:0] dataD2_q;
    logic [DATA_W-1:0] dataD3_q;
    logic [DATA_W-1:0] dataD4_q;

    // a level counts only once stages two and three agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_q <= 3'h7;
            pinS2_q <= 3'h7;
            pinS3_q <= 3'h7;
            pinF_q <= 3'h7;
        end else begin
            pinS1_q <= {bus.csN, bus.strobeN, bus.wrRwN};
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
            for (int i = 0; i < 3; i++) begin
                if (pinS2_q[i] == pinS3_q[i]) begin
                    pinF_q[i] <= pinS3_q[i];
                end
            end
        end
    end

    // address and data are stable while the strobe is low
    // data lags as long as the strobe filter, else a host that
    // floats the bus right after its strobe rises would be stored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addrS_q <= 7'h00;
            dataS_q <= 8'h00;
            dataD2_q <= 8'h00;
            dataD3_q <= 8'h00;
            dataD4_q <= 8'h00;
        end else begin
            addrS_q <= bus.addr;
            dataS_q <= bus.dataBus;
            dataD2_q <= dataS_q;
            dataD3_q <= dataD2_q;
            dataD4_q <= dataD3_q;
        end
    end

    logic csLow;
    logic stbLow;
    logic wrRwHigh;
    assign csLow = !pinF_q[2];
    assign stbLow = !pinF_q[1];
    assign wrRwHigh = pinF_q[0];

    // ************************************************************
    // style selection
    // ************************************************************
    hrap_mode_t mode_q;
    logic strapTaken_q;
    logic csPrev_q;
    logic [3:0] detCnt_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strapTaken_q <= 1'b0;
            mode_q <= MODE_UNDET;
        end else if (!strapTaken_q) begin
            strapTaken_q <= 1'b1;
            mode_q <= bus.strap ? MODE_SEP : MODE_UNDET;
        end else if (mode_q == MODE_UNDET) begin
            if (csLow && stbLow) begin
                // tenth cycle falls to normal; host keeps clear of it
                if (wrRwHigh && detCnt_q >= DET_SAR_MIN) begin
                    mode_q <= MODE_SAR;
                end else begin
                    mode_q <= MODE_NORMAL;
                end
            end else if (csPrev_q && !csLow) begin
                mode_q <= MODE_SAR;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            csPrev_q <= 1'b0;
            detCnt_q <= 4'h0;
        end else begin
            csPrev_q <= csLow;
            if (!csLow) begin
                detCnt_q <= 4'h0;
            end else if (detCnt_q != DET_CNT_MAX) begin
                detCnt_q <= detCnt_q + 4'h1;
            end
        end
    end

    // ************************************************************
    // access recognition
    // ************************************************************
    logic active;
    logic isRead;

    always_comb begin
        active = 1'b0;
        isRead = 1'b0;
        unique case (mode_q)
            MODE_SEP: begin
                active = csLow && (stbLow != !wrRwHigh);
                isRead = stbLow;
            end
            MODE_NORMAL: begin
                active = csLow && stbLow;
                isRead = wrRwHigh;
            end
            MODE_SAR: begin
                // companion style frames the access by select alone
                active = csLow;
                isRead = wrRwHigh;
            end
            MODE_UNDET: begin
                active = 1'b0;
                isRead = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // handshake and register file
    // ************************************************************
    hrap_acc_t acc_q;
    logic accRead_q;
    logic [ADDR_W-1:0] accAddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [2:0] latCnt_q;
    logic [4:0] quiet_q;
    logic [DATA_W-1:0] regs_q [REG_NUM];
    logic finish;
    logic swReset;

    assign finish = (acc_q != ACC_IDLE) && !active;
    assign swReset = finish && !accRead_q && accAddr_q == CMD2_ADDR
        && wdata_q[CMD2_SWRST_BIT];

    // latency depends on the register, never above the ack limit
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_q <= ACC_IDLE;
            accRead_q <= 1'b0;
            accAddr_q <= 7'h00;
            latCnt_q <= 3'h0;
        end else begin
            unique case (acc_q)
                ACC_IDLE: begin
                    if (active && quiet_q == 5'h00) begin
                        acc_q <= ACC_WAIT;
                        accRead_q <= isRead;
                        accAddr_q <= addrS_q;
                        latCnt_q <= ACK_LAT_MIN + {2'b00, addrS_q[0]} - 3'h1;
                    end
                end
                ACC_WAIT: begin
                    if (!active) begin
                        acc_q <= ACC_IDLE;
                    end else if (latCnt_q == 3'h0) begin
                        acc_q <= ACC_ACK;
                    end else begin
                        latCnt_q <= latCnt_q - 3'h1;
                    end
                end
                ACC_ACK: begin
                    if (!active) begin
                        acc_q <= ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // last value seen before the strobe rises is the one stored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdata_q <= 8'h00;
        end else if (active) begin
            wdata_q <= dataD4_q;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (swReset) begin
            for (int i = 0; i < REG_NUM; i++) begin
                regs_q[i] <= REG_RESET;
            end
        end else if (finish && !accRead_q) begin
            regs_q[accAddr_q] <= wdata_q;
        end
    end

    // accesses inside the quiet window are not answered
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            quiet_q <= 5'h00;
        end else if (swReset) begin
            quiet_q <= QUIET_CYC;
        end else if (quiet_q != 5'h00) begin
            quiet_q <= quiet_q - 5'h01;
        end
    end

    // ************************************************************
    // pin drivers
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bus.ackN <= 1'b1;
            bus.ackOeN <= 1'b1;
            bus.devData <= 8'h00;
            bus.devDataOeN <= 1'b1;
        end else begin
            bus.ackOeN <= !csLow;
            bus.ackN <= !(acc_q == ACC_ACK && active);
            bus.devDataOeN <= !(csLow && acc_q == ACC_ACK && accRead_q);
            bus.devData <= regs_q[accAddr_q];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            styleMode <= MODE_UNDET;
            quietBusy <= 1'b0;
        end else begin
            styleMode <= mode_q;
            quietBusy <= quiet_q != 5'h00;
        end
    end

endmodule

// ### logic/hrap_host.sv
// host end of the register access port: drives one access per request
`timescale 1ns/1ps
module hrap_host
    import hrap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // device pins
    hrap_if.host bus,
    // user request
    input wire logic strapLevel,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqWdata,
    output logic reqReady,
    // user answer
    output logic rspValid,
    output logic [DATA_W-1:0] rspData
);

    // ************************************************************
    // acknowledge synchroniser
    // ************************************************************
    logic ackS1_q;
    logic ackS2_q;
    logic ackS3_q;
    logic ackLow_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ackS1_q <= 1'b1;
            ackS2_q <= 1'b1;
            ackS3_q <= 1'b1;
            ackLow_q <= 1'b0;
        end else begin
            ackS1_q <= bus.ackBus;
            ackS2_q <= ackS1_q;
            ackS3_q <= ackS2_q;
            if (ackS2_q == ackS3_q) begin
                ackLow_q <= !ackS3_q;
            end
        end
    end

    // ************************************************************
    // access sequencer
    // ************************************************************
    hrap_host_t st_q;
    logic [4:0] cnt_q;
    logic write_q;
    logic resetWrite_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= HST_IDLE;
            cnt_q <= 5'h00;
            write_q <= 1'b0;
            resetWrite_q <= 1'b0;
            reqReady <= 1'b0;
            rspValid <= 1'b0;
            rspData <= 8'h00;
            bus.csN <= 1'b1;
            bus.strobeN <= 1'b1;
            bus.wrRwN <= 1'b1;
            bus.addr <= 7'h00;
            bus.hostData <= 8'h00;
            bus.hostDataOeN <= 1'b1;
            bus.strap <= 1'b0;
        end else begin
            bus.strap <= strapLevel;
            rspValid <= 1'b0;
            unique case (st_q)
                HST_IDLE: begin
                    reqReady <= 1'b1;
                    if (reqValid && reqReady) begin
                        reqReady <= 1'b0;
                        write_q <= reqWrite;
                        resetWrite_q <= reqWrite && reqAddr == CMD2_ADDR
                            && reqWdata[CMD2_SWRST_BIT];
                        bus.addr <= reqAddr;
                        bus.hostData <= reqWdata;
                        bus.hostDataOeN <= !reqWrite;
                        bus.csN <= 1'b0;
                        // separate strobes keep the shared line high for reads
                        bus.wrRwN <= strapLevel ? 1'b1 : !reqWrite;
                        st_q <= HST_SETUP;
                    end
                end
                HST_SETUP: begin
                    // strobe falls one cycle after select, far from cycle ten
                    if (strapLevel && write_q) begin
                        bus.wrRwN <= 1'b0;
                    end else begin
                        bus.strobeN <= 1'b0;
                    end
                    cnt_q <= 5'h00;
                    st_q <= HST_STROBE;
                end
                HST_STROBE: begin
                    cnt_q <= cnt_q + 5'h01;
                    if ((ackLow_q && cnt_q >= {2'b00, ACK_MAX_CYC}) ||
                            cnt_q == HOST_ACK_TIMEOUT) begin
                        bus.strobeN <= 1'b1;
                        if (strapLevel) begin
                            bus.wrRwN <= 1'b1;
                        end
                        rspData <= bus.dataBus;
                        rspValid <= !write_q;
                        st_q <= HST_RELEASE;
                    end
                end
                HST_RELEASE: begin
                    bus.csN <= 1'b1;
                    bus.hostDataOeN <= 1'b1;
                    bus.wrRwN <= 1'b1;
                    cnt_q <= resetWrite_q ? QUIET_CYC : RECOVERY_CYC;
                    st_q <= HST_RECOVER;
                end
                HST_RECOVER: begin
                    if (cnt_q == 5'h00) begin
                        st_q <= HST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 5'h01;
                    end
                end
                default: begin
                    st_q <= HST_IDLE;
                end
            endcase
        end
    end

endmodule

// ### logic/hrap_if.sv
// pin-level carrier between host end and device end
`timescale 1ns/1ps
interface hrap_if;
    import hrap_pkg::*;

    logic csN;
    logic strobeN;
    logic wrRwN;
    logic [ADDR_W-1:0] addr;
    logic strap;
    logic [DATA_W-1:0] hostData;
    logic hostDataOeN;
    logic [DATA_W-1:0] devData;
    logic devDataOeN;
    logic ackN;
    logic ackOeN;
    logic [DATA_W-1:0] dataBus;
    logic ackBus;

    // undriven lines read as pulled high
    always_comb begin
        if (!devDataOeN) begin
            dataBus = devData;
        end else if (!hostDataOeN) begin
            dataBus = hostData;
        end else begin
            dataBus = 8'hff;
        end
        ackBus = ackOeN ? 1'b1 : ackN;
    end

    modport dev (
        input csN, strobeN, wrRwN, addr, strap, dataBus,
        output devData, devDataOeN, ackN, ackOeN
    );

    modport host (
        output csN, strobeN, wrRwN, addr, strap, hostData, hostDataOeN,
        input dataBus, ackBus
    );
endinterface

// ### logic/hrap_pkg.sv
// shared constants and types for the host register access port
package hrap_pkg;

    // ************************************************************
    // bus widths and register map
    // ************************************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int REG_NUM = 128;
    localparam logic [6:0] CMD2_ADDR = 7'h01;
    localparam int CMD2_SWRST_BIT = 0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ************************************************************
    // timing counts in device clock periods, and the clock period in ns
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [3:0] DET_SAR_MIN = 4'hb;
    localparam logic [3:0] DET_CNT_MAX = 4'hf;
    localparam logic [2:0] ACK_MAX_CYC = 3'h4;
    localparam logic [2:0] ACK_LAT_MIN = 3'h1;
    localparam logic [4:0] RECOVERY_CYC = 5'h04;
    localparam logic [4:0] QUIET_CYC = 5'h14;
    localparam logic [4:0] HOST_ACK_TIMEOUT = 5'h10;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_UNDET = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_SAR = 2'b11,
        MODE_SEP = 2'b10
    } hrap_mode_t;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_ACK = 2'b11
    } hrap_acc_t;

    typedef enum logic [2:0] {
        HST_IDLE = 3'b000,
        HST_SETUP = 3'b001,
        HST_STROBE = 3'b011,
        HST_RELEASE = 3'b010,
        HST_RECOVER = 3'b110
    } hrap_host_t;

endpackage
